/* pss_cmd_source.sv */
// partner: command source for flags, digital inputs, control word and run
`timescale 1ns/1ns
module pss_cmd_source (
    // clock and requests {ctrl, ext, local, second, high}
    input  wire logic        clk_sys,
    input  wire logic [29:0] reqLevels,
    input  wire logic        reqRun,
    // levels at the block
    output logic             high_freq_threshold_flag,
    output logic             second_freq_threshold_flag,
    output logic [5:0]       localDi,
    output logic [5:0]       extDi,
    output logic [15:0]      ctrlWord,
    output logic             runCmd
);
    // lines follow the requests at once; a second falling-edge stage would race the bench
    assign {ctrlWord, extDi, localDi, second_freq_threshold_flag,
        high_freq_threshold_flag} = reqLevels;
    assign runCmd = reqRun;
endmodule // pss_cmd_source

/* pss_pkg.sv */
// package: constants and types for parameter set switching and low-speed sleep
package pss_pkg;
    // selector source codes
    localparam logic [4:0] SRC_NONE  = 5'h00;
    localparam logic [4:0] SRC_HIGHF = 5'h01;
    localparam logic [4:0] SRC_SECF  = 5'h02;
    localparam logic [4:0] SRC_DI1   = 5'h03;  // 03..08 local inputs 1..6
    localparam logic [4:0] SRC_DI11  = 5'h09;  // 09..0E extension inputs 11..16
    localparam logic [4:0] SRC_CW0   = 5'h0F;  // 0F..1E control word bits 0..15
    localparam logic [4:0] SRC_CWEND = 5'h1E;
    localparam int         NUM_DI    = 6;
    localparam int         NUM_CW    = 16;
    // set index encoding
    localparam logic [1:0] SET1 = 2'h0;
    localparam logic [1:0] SET2 = 2'h1;
    localparam logic [1:0] SET3 = 2'h2;
    localparam int         MAX_PARAMS = 15;
    // timing: timeout in tenths of a second
    localparam int          TICK_MS      = 100;
    localparam int          CLK_KHZ      = 25000;
    localparam int          TICK_CYCLES  = TICK_MS * CLK_KHZ;
    localparam logic [13:0] TIMEOUT_MAX  = 14'h270F;  // 999.9 s
    localparam logic [13:0] TIMEOUT_RST  = 14'h0000;
    localparam logic [15:0] OFFSET_RST   = 16'h000A;  // 1.0 Hz in 0.1 Hz units
    localparam logic [15:0] OFFSET_MIN   = 16'h000A;
    typedef enum logic [1:0] {PSS_RUN, PSS_SLEEP} pss_state_t;
endpackage

/* pss_sel_mux.sv */
// selector source multiplexer: turns a source code into one logic level
`timescale 1ns/1ns
module pss_sel_mux (
    // source choice
    input  wire logic [4:0]  srcSel,
    // candidate levels
    input  wire logic        highFreqFlag,
    input  wire logic        secondFreqFlag,
    input  wire logic [5:0]  localDi,
    input  wire logic [5:0]  extDi,
    input  wire logic [15:0] ctrlWord,
    // result
    output logic             level
);
    import pss_pkg::*;
    logic [4:0] idx;
    // threshold flags act as plain inputs: reached reads one
    always_comb begin
        idx   = 5'h00;
        level = 1'b0;
        if (srcSel == SRC_HIGHF) begin
            level = highFreqFlag;
        end else if (srcSel == SRC_SECF) begin
            level = secondFreqFlag;
        end else if (srcSel >= SRC_DI1 && srcSel < SRC_DI11) begin
            idx   = srcSel - SRC_DI1;
            level = localDi[idx[2:0]];
        end else if (srcSel >= SRC_DI11 && srcSel < SRC_CW0) begin
            idx   = srcSel - SRC_DI11;
            level = extDi[idx[2:0]];
        end else if (srcSel >= SRC_CW0 && srcSel <= SRC_CWEND) begin
            idx   = srcSel - SRC_CW0;
            level = ctrlWord[idx[3:0]];
        end
    end
endmodule // pss_sel_mux

/* pss_top.sv */
// top: parameter set switching and low-speed sleep control
// How it works
// - one to fifteen parameters, each three values
// - selectors come from inputs or control bits
// - selector two high picks set three once selector one is assigned
// - frequency thresholds read as logic inputs
// - set changes apply while motor runs
// - parameter list shown only with selector one
// - selectors: threshold flags, inputs, control bits
// - sleep logic only in speed control
// - both frequencies low for timeout: stop
// - timeout stop uses active deceleration ramp
// - any frequency rising cancels pending stop
// - restart when reference rises, run present
// - timeout zero to 999.9 s, zero disables
// - offset adjustable only with nonzero timeout
// - offset from 1.0 Hz to max frequency
`timescale 1ns/1ns
module pss_top #(
    parameter int NPARAM      = pss_pkg::MAX_PARAMS,
    parameter int PW          = 16,
    parameter int TICK_CYCLES = pss_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   clkEn,
    // selector configuration and sources
    input  wire logic [4:0]             sel1Src,
    input  wire logic [4:0]             sel2Src,
    input  wire logic                   high_freq_threshold_flag,
    input  wire logic                   second_freq_threshold_flag,
    input  wire logic [5:0]             localDi,
    input  wire logic [5:0]             extDi,
    input  wire logic [15:0]            ctrlWord,
    // stored value sets, parameter i at [i*PW +: PW]
    input  wire logic [NPARAM-1:0]      paramEnable,
    input  wire logic [NPARAM*PW-1:0]   set1Values,
    input  wire logic [NPARAM*PW-1:0]   set2Values,
    input  wire logic [NPARAM*PW-1:0]   set3Values,
    // sleep settings, frequencies in 0.1 Hz
    input  wire logic                   speedCtrlMode,
    input  wire logic                   runCmd,
    input  wire logic [13:0]            timeoutSetting,
    input  wire logic                   timeoutWrite,
    input  wire logic [15:0]            offsetSetting,
    input  wire logic                   offsetWrite,
    input  wire logic [15:0]            maxFreq,
    input  wire logic [15:0]            low_speed_limit,
    input  wire logic [15:0]            preRampRefFreq,
    input  wire logic [15:0]            outputFreq,
    // outputs
    output logic [1:0]                  activeSet,
    output logic [NPARAM*PW-1:0]        activeValues,
    output logic                        paramListVisible,
    output logic                        offsetEditable,
    output logic [13:0]                 lowSpeedTimeout,
    output logic [15:0]                 sleep_offset_freq,
    output logic                        sleepStop,
    output logic                        runOut
);
    import pss_pkg::*;

    // ----------------------------------------
    // selector decode
    // ----------------------------------------
    logic sel1Level;
    logic sel2Level;
    logic [1:0] setD;

    pss_sel_mux uSel1 (
        .srcSel         (sel1Src),
        .highFreqFlag   (high_freq_threshold_flag),
        .secondFreqFlag (second_freq_threshold_flag),
        .localDi        (localDi),
        .extDi          (extDi),
        .ctrlWord       (ctrlWord),
        .level          (sel1Level)
    );
    pss_sel_mux uSel2 (
        .srcSel         (sel2Src),
        .highFreqFlag   (high_freq_threshold_flag),
        .secondFreqFlag (second_freq_threshold_flag),
        .localDi        (localDi),
        .extDi          (extDi),
        .ctrlWord       (ctrlWord),
        .level          (sel2Level)
    );

    // second selector only counts once the first is assigned
    always_comb begin
        if (sel1Src == SRC_NONE) begin
            setD = SET1;
        end else if (sel2Level) begin
            setD = SET3;
        end else if (sel1Level) begin
            setD = SET2;
        end else begin
            setD = SET1;
        end
    end

    // set register, no run interlock on purpose
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            activeSet        <= SET1;
            paramListVisible <= 1'b0;
        end else if (clkEn) begin
            activeSet        <= setD;
            paramListVisible <= (sel1Src != SRC_NONE);
        end
    end

    // ----------------------------------------
    // per-parameter value routing
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPARAM; gi++) begin : gParam
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    activeValues[gi*PW +: PW] <= '0;
                end else if (clkEn) begin
                    // unselected parameters keep set 1 value
                    if (!paramEnable[gi] || setD == SET1) begin
                        activeValues[gi*PW +: PW] <= set1Values[gi*PW +: PW];
                    end else if (setD == SET2) begin
                        activeValues[gi*PW +: PW] <= set2Values[gi*PW +: PW];
                    end else begin
                        activeValues[gi*PW +: PW] <= set3Values[gi*PW +: PW];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // sleep settings
    // ----------------------------------------
    // writes clamp into range rather than being refused
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lowSpeedTimeout <= TIMEOUT_RST;
        end else if (clkEn && timeoutWrite) begin
            lowSpeedTimeout <= (timeoutSetting > TIMEOUT_MAX) ? TIMEOUT_MAX
                                                              : timeoutSetting;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sleep_offset_freq <= OFFSET_RST;
            offsetEditable    <= 1'b0;
        end else if (clkEn) begin
            offsetEditable <= (lowSpeedTimeout != TIMEOUT_RST);
            if (offsetWrite && lowSpeedTimeout != TIMEOUT_RST) begin
                if (offsetSetting < OFFSET_MIN) begin
                    sleep_offset_freq <= OFFSET_MIN;
                end else if (offsetSetting > maxFreq) begin
                    sleep_offset_freq <= maxFreq;
                end else begin
                    sleep_offset_freq <= offsetSetting;
                end
            end
        end
    end

    // ----------------------------------------
    // low-speed timer and sleep state
    // ----------------------------------------
    logic [16:0] thresh;
    logic        refLow;
    logic        outLow;
    logic        active;
    logic [31:0] tickCnt_q;
    logic [13:0] tenths_q;
    pss_state_t  state_q;

    assign thresh = {1'b0, low_speed_limit} + {1'b0, sleep_offset_freq};
    assign refLow = {1'b0, preRampRefFreq} < thresh;
    assign outLow = {1'b0, outputFreq} < thresh;
    assign active = speedCtrlMode && (lowSpeedTimeout != TIMEOUT_RST);

    // counts only while both are low; any rise clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_q <= '0;
            tenths_q  <= '0;
        end else if (clkEn) begin
            if (!active || state_q != PSS_RUN || !refLow || !outLow || !runCmd) begin
                tickCnt_q <= '0;
                tenths_q  <= '0;
            end else if (tickCnt_q == 32'(TICK_CYCLES - 1)) begin
                tickCnt_q <= '0;
                if (tenths_q != TIMEOUT_MAX) begin
                    tenths_q <= tenths_q + 14'h0001;
                end
            end else begin
                tickCnt_q <= tickCnt_q + 32'h00000001;
            end
        end
    end

    // sleepStop asks the ramp generator to stop on its current decel ramp
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= PSS_RUN;
            sleepStop <= 1'b0;
            runOut    <= 1'b0;
        end else if (clkEn) begin
            unique case (state_q)
                PSS_RUN: begin
                    if (active && refLow && outLow && runCmd
                        && tenths_q >= lowSpeedTimeout) begin
                        state_q <= PSS_SLEEP;
                    end
                end
                PSS_SLEEP: begin
                    if (!active || !runCmd || !refLow) begin
                        state_q <= PSS_RUN;
                    end
                end
                default: state_q <= PSS_RUN;
            endcase
            sleepStop <= (state_q == PSS_SLEEP);
            runOut    <= runCmd && (state_q != PSS_SLEEP);
        end
    end
endmodule // pss_top

/* pss_top_assertions.sv */
// checker: port-level assertions for pss_top
`timescale 1ns/1ns
module pss_top_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        clkEn,
    // observed inputs
    input wire logic [4:0]  sel1Src,
    input wire logic [4:0]  sel2Src,
    input wire logic        high_freq_threshold_flag,
    input wire logic        second_freq_threshold_flag,
    input wire logic        speedCtrlMode,
    input wire logic [13:0] timeoutSetting,
    input wire logic        timeoutWrite,
    input wire logic        offsetWrite,
    input wire logic [15:0] low_speed_limit,
    input wire logic [15:0] preRampRefFreq,
    // observed outputs
    input wire logic [1:0]  activeSet,
    input wire logic        paramListVisible,
    input wire logic        offsetEditable,
    input wire logic [13:0] lowSpeedTimeout,
    input wire logic [15:0] sleep_offset_freq,
    input wire logic        sleepStop,
    input wire logic        runOut
);
    import pss_pkg::*;
    // ----
    // properties
    // ----
    // one domain, so clock and reset are declared once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    set1_none_a: assert property (clkEn && sel1Src == SRC_NONE |=> activeSet == SET1)
        else $error("set one not chosen without first selector");
    set2_pick_a: assert property (clkEn && sel1Src == SRC_SECF && second_freq_threshold_flag
        && sel2Src == SRC_HIGHF && !high_freq_threshold_flag |=> activeSet == SET2)
        else $error("set two not chosen");
    set3_pick_a: assert property (clkEn && sel1Src != SRC_NONE && sel2Src == SRC_HIGHF
        && high_freq_threshold_flag |=> activeSet == SET3)
        else $error("set three not chosen");
    list_vis_a: assert property (clkEn |=> paramListVisible == ($past(sel1Src) != 5'h00))
        else $error("list visibility wrong");
    offset_edit_a: assert property (clkEn |=> offsetEditable == ($past(lowSpeedTimeout) != 0))
        else $error("offset editability wrong");
    timeout_clamp_a: assert property (clkEn && timeoutWrite |=> lowSpeedTimeout ==
        (($past(timeoutSetting) > TIMEOUT_MAX) ? TIMEOUT_MAX : $past(timeoutSetting)))
        else $error("timeout write wrong");
    offset_lock_a: assert property (clkEn && offsetWrite && lowSpeedTimeout == 14'h0000
        |=> $stable(sleep_offset_freq)) else $error("offset changed while locked");
    stop_norun_a: assert property (sleepStop |-> !runOut)
        else $error("run kept during sleep stop");
    mode_off_a: assert property ((clkEn && !speedCtrlMode) [*3] |-> !sleepStop)
        else $error("sleep outside speed control");
    wake_ref_a: assert property ((clkEn && {1'b0, preRampRefFreq} >=
        {1'b0, low_speed_limit} + {1'b0, sleep_offset_freq}) [*3] |-> !sleepStop)
        else $error("no restart on high reference");
    // main scenarios reached
    cover property (sleepStop);
    cover property (activeSet == SET3);
    cover property (timeoutWrite);
endmodule // pss_top_checker
bind pss_top pss_top_checker u_chk (.clk_sys, .rst_n, .clkEn, .sel1Src, .sel2Src,
    .high_freq_threshold_flag, .second_freq_threshold_flag, .speedCtrlMode, .timeoutSetting,
    .timeoutWrite, .offsetWrite, .low_speed_limit, .preRampRefFreq, .activeSet,
    .paramListVisible, .offsetEditable, .lowSpeedTimeout, .sleep_offset_freq, .sleepStop,
    .runOut);

/* tb_top.sv */
// testbench: scenarios for set switching and low-speed sleep
`timescale 1ns/1ns
module tb_top;
    import pss_pkg::*;
    // ----
    // stimulus and observation
    // ----
    logic clk_sys = 1'b0, rst_n = 1'b0, reqRun = 1'b0, speedCtrlMode = 1'b1;
    logic [29:0] reqLevels = 30'h0;
    logic [4:0]  sel1Src = SRC_NONE, sel2Src = SRC_NONE;
    logic [13:0] timeoutSetting = 14'h0, lowSpeedTimeout;
    logic timeoutWrite = 1'b0, offsetWrite = 1'b0, clkEn = 1'b1;
    logic [15:0] offsetSetting = 16'h0, maxFreq = 16'h01F4, low_speed_limit = 16'h0064;
    logic [15:0] preRampRefFreq = 16'h012C, outputFreq = 16'h012C, sleep_offset_freq, ctrlWord;
    logic [1:0]  paramEnable = 2'h1, activeSet;
    logic [31:0] set1Values = 32'h11111111, set2Values = 32'h22222222;
    logic [31:0] set3Values = 32'h33333333, activeValues;
    logic high_freq_threshold_flag, second_freq_threshold_flag, runCmd;
    logic [5:0]  localDi, extDi;
    logic paramListVisible, offsetEditable, sleepStop, runOut;
    int numErrors = 0, numChecks = 0;
    always #20 clk_sys = ~clk_sys;
    pss_cmd_source u_src (.clk_sys, .reqLevels, .reqRun, .high_freq_threshold_flag,
        .second_freq_threshold_flag, .localDi, .extDi, .ctrlWord, .runCmd);
    // short tick of four cycles per tenth, so a timeout of a few tenths stays about a dozen cycles
    pss_top #(.NPARAM(2), .PW(16), .TICK_CYCLES(4)) u_dut (.clk_sys, .rst_n, .clkEn,
        .sel1Src, .sel2Src, .high_freq_threshold_flag, .second_freq_threshold_flag, .localDi,
        .extDi, .ctrlWord, .paramEnable, .set1Values, .set2Values, .set3Values, .speedCtrlMode,
        .runCmd, .timeoutSetting, .timeoutWrite, .offsetSetting, .offsetWrite, .maxFreq,
        .low_speed_limit, .preRampRefFreq, .outputFreq, .activeSet, .activeValues,
        .paramListVisible, .offsetEditable, .lowSpeedTimeout, .sleep_offset_freq, .sleepStop,
        .runOut);
    // ----
    // helpers
    // ----
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic completeRun();
        if (numErrors == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // strobes last one cycle, result read two cycles on
    task automatic wrT(input logic [13:0] v);
        timeoutSetting = v;
        timeoutWrite = 1'b1;
        step(1);
        timeoutWrite = 1'b0;
        step(2);
    endtask
    task automatic wrO(input logic [15:0] v);
        offsetSetting = v;
        offsetWrite = 1'b1;
        step(1);
        offsetWrite = 1'b0;
        step(2);
    endtask
    // bounded wait: sleepStop reaching a level
    task automatic waitSleep(input logic v, input int lim);
        for (int k = 0; k < lim && sleepStop !== v; k++) step(1);
    endtask
    // all four selector combinations while the motor runs
    task automatic trySet(input logic [4:0] s1, input logic [4:0] s2, input int p1, p2);
        logic [15:0] v;
        sel1Src = s1;
        sel2Src = s2;
        for (int i = 0; i < 4; i++) begin
            reqLevels = (30'(i % 2) << p1) | (30'(i / 2) << p2);
            step(3);
            v = (i / 2) ? 16'h3333 : (i % 2) ? 16'h2222 : 16'h1111;
            chk("activeSet", (i / 2) ? SET3 : (i % 2) ? SET2 : SET1, activeSet);
            chk("activeValues", {16'h1111, v}, activeValues);
        end
    endtask
    // values straight after reset release
    task automatic resetValues();
        chk("activeSet", SET1, activeSet);
        chk("timeout", TIMEOUT_RST, lowSpeedTimeout);
        chk("offset", OFFSET_RST, sleep_offset_freq);
    endtask
    // second selector alone is ignored, first one opens the list, low enable freezes
    task automatic selGate();
        sel1Src = SRC_NONE;
        sel2Src = SRC_HIGHF;
        reqLevels = 30'h1;
        step(3);
        chk("activeSet", SET1, activeSet);
        chk("listVisible", 0, paramListVisible);
        sel1Src = SRC_SECF;
        step(3);
        chk("listVisible", 1, paramListVisible);
        chk("activeSet", SET3, activeSet);
        clkEn = 1'b0;
        sel1Src = SRC_NONE;
        step(3);
        chk("frozenSet", SET3, activeSet);
        chk("frozenList", 1, paramListVisible);
        clkEn = 1'b1;
        step(3);
        chk("activeSet", SET1, activeSet);
        chk("listVisible", 0, paramListVisible);
    endtask
    // locked offset, clamps at both ends, then sleep setup at 15.0 Hz threshold
    task automatic settingLimits();
        wrO(16'h0032);
        chk("offset", OFFSET_RST, sleep_offset_freq);
        wrT(14'h3FFF);
        chk("timeout", TIMEOUT_MAX, lowSpeedTimeout);
        chk("editable", 1, offsetEditable);
        wrO(16'h0005);
        chk("offset", OFFSET_MIN, sleep_offset_freq);
        wrO(16'hFFFF);
        chk("offset", maxFreq, sleep_offset_freq);
        wrO(16'h0032);
        wrT(14'h0003);
    endtask
    // low speed, a one-cycle rise of output frequency restarts the wait, then wake
    task automatic sleepWake();
        preRampRefFreq = 16'h0078;
        outputFreq = 16'h0078;
        step(9);
        chk("sleepStop", 0, sleepStop);
        outputFreq = 16'h00C8;
        step(1);
        outputFreq = 16'h0078;
        step(9);
        chk("sleepStop", 0, sleepStop);
        waitSleep(1'b1, 20);
        chk("sleepStop", 1, sleepStop);
        chk("runOut", 0, runOut);
        preRampRefFreq = 16'h00A0;
        waitSleep(1'b0, 6);
        chk("sleepStop", 0, sleepStop);
        step(1);
        chk("runOut", 1, runOut);
    endtask
    // no stop outside speed control, none with timeout zero
    task automatic sleepBlocked();
        speedCtrlMode = 1'b0;
        preRampRefFreq = 16'h0078;
        step(30);
        chk("sleepStop", 0, sleepStop);
        wrT(14'h0000);
        speedCtrlMode = 1'b1;
        step(30);
        chk("sleepStop", 0, sleepStop);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        step(16);
        rst_n = 1'b1;
        step(1);
        resetValues();
        reqRun = 1'b1;
        trySet(SRC_DI1, SRC_CW0 + 5'h03, 2, 17);
        trySet(SRC_SECF, SRC_HIGHF, 1, 0);
        trySet(SRC_DI11 + 5'h05, SRC_DI1 + 5'h05, 13, 7);
        selGate();
        settingLimits();
        sleepWake();
        sleepBlocked();
        completeRun();
    end
    // watchdog, far beyond the under two hundred cycles of the sequence
    initial begin
        #200000;
        numErrors++;
        completeRun();
    end
endmodule // tb_top
